/* hdl/usart_rx_pkg.sv */
package usart_rx_pkg;

    // Operating modes of the mode select field
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_SPI = 2'h3;

    // Character size codes
    localparam logic [2:0] SIZE_EIGHT = 3'h3;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [3:0] BITS_BASE = 4'h5;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic [3:0] SPI_BITS = 4'h8;
    localparam logic [3:0] SPI_TOP_INDEX = 4'h7;

    // Oversampling ratios and centre sample positions
    localparam logic [4:0] OS_NORMAL = 5'h10;
    localparam logic [4:0] OS_DOUBLE = 5'h08;
    localparam logic [4:0] NORMAL_S0 = 5'h08;
    localparam logic [4:0] NORMAL_S1 = 5'h09;
    localparam logic [4:0] NORMAL_S2 = 5'h0A;
    localparam logic [4:0] DOUBLE_S0 = 5'h04;
    localparam logic [4:0] DOUBLE_S1 = 5'h05;
    localparam logic [4:0] DOUBLE_S2 = 5'h06;
    localparam logic [1:0] VOTE_MAJORITY = 2'h2;

    // Receive buffer depth and reset values
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [8:0] DATA_RESET = 9'h000;
    localparam logic [7:0] BAUD_RESET = 8'h00;

    // Configuration bits software sets up before reception
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] char_size;
        logic parity_enable;
        logic parity_odd;
        logic double_speed;
        logic master;
        logic clock_polarity;
        logic lsb_first;
        logic slave_select_out_enable;
        logic rx_complete_irq_enable;
        logic global_irq_enable;
        logic [7:0] baud_div;
    } rx_config_type;

    // One receive buffer entry with its own error flags
    typedef struct packed {
        logic [8:0] data;
        logic frame_error;
        logic overrun;
        logic parity_error;
    } rx_entry_type;

    // Receiver states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_START = 5'h02,
        ST_DATA = 5'h04,
        ST_PARITY = 5'h08,
        ST_STOP = 5'h10
    } rx_state_type;

endpackage : usart_rx_pkg

/* hdl/usart_receiver_spi_select.sv */
`timescale 1ns/1ns
module usart_receiver_spi_select (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic rx_enable_bit_in, // Receiver enable
    input wire usart_rx_pkg::rx_config_type config_in, // Static configuration
    input wire logic rx_data_pin_in, // Serial receive line
    input wire logic serial_clock_pin_in, // Serial clock in sync and SPI modes
    input wire logic slave_select_pin_n_in, // Active-low slave select
    input wire logic data_read_in, // One-cycle read of the data buffer
    output logic [7:0] data_buffer_reg_out,
    output logic rx_ninth_bit_out,
    output logic frame_error_flag_out,
    output logic overrun_flag_out,
    output logic parity_error_flag_out,
    output logic rx_complete_flag_out,
    output logic rx_irq_out,
    output logic rx_pin_claim_out,
    output logic slave_select_pin_out,
    output logic slave_select_pin_oe_out
);

    // Mode decode
    logic is_async; // Oversampled asynchronous mode
    logic is_spi; // SPI mode, fixed eight bits
    logic spi_selected; // Master, or slave with select low
    logic [3:0] frame_bits; // Data bits per character
    logic [4:0] os_ratio; // Samples per bit
    logic [4:0] pos_a;
    logic [4:0] pos_b;
    logic [4:0] pos_c;

    // Oversampling tick generator
    logic [7:0] baud_cnt_reg;
    logic os_tick;

    // Line and clock history
    logic line_prev_reg; // Line at previous oversample tick
    logic sclk_prev_reg;
    logic sample_edge;

    // Bit timing and voting
    logic [4:0] sample_cnt_reg;
    logic [4:0] sample_num;
    logic [1:0] high_votes_reg;
    logic vote_high;
    logic bit_strobe; // Bit value decided now
    logic bit_end; // Bit period over
    logic bit_value;

    // Frame assembly
    usart_rx_pkg::rx_state_type state_reg;
    logic [3:0] bit_idx_reg;
    logic [3:0] bit_pos;
    logic [8:0] shift_reg;
    logic [8:0] spi_word; // Shift register with the bit arriving now in place
    logic parity_bit_reg;
    logic parity_bad;
    logic frame_done_reg;
    usart_rx_pkg::rx_entry_type frame_entry_reg;

    // Receive buffer
    usart_rx_pkg::rx_entry_type entry_reg [2];
    usart_rx_pkg::rx_entry_type head_entry;
    logic head_reg;
    logic [1:0] count_reg;
    logic lost_reg; // Frames dropped until next read
    logic pop;
    logic push;
    logic overrun_now;
    logic tail;

    // Output flops
    logic [7:0] data_out_reg;
    logic ninth_out_reg;
    logic fe_out_reg;
    logic dor_out_reg;
    logic pe_out_reg;
    logic rxc_out_reg;
    logic irq_out_reg;
    logic claim_reg;
    logic ss_out_reg;
    logic ss_oe_reg;

    // Mode and format decode
    always_comb
    begin
        is_async = (config_in.mode == usart_rx_pkg::MODE_ASYNC);
        is_spi = (config_in.mode == usart_rx_pkg::MODE_SPI);
        spi_selected = config_in.master | ~slave_select_pin_n_in;
        if (is_spi)
        begin
            frame_bits = usart_rx_pkg::SPI_BITS;
        end
        else if (config_in.char_size == usart_rx_pkg::SIZE_NINE)
        begin
            frame_bits = usart_rx_pkg::BITS_NINE;
        end
        else if (config_in.char_size > usart_rx_pkg::SIZE_EIGHT)
        begin
            // Reserved sizes fall back to eight bits
            frame_bits = usart_rx_pkg::BITS_EIGHT;
        end
        else
        begin
            frame_bits = usart_rx_pkg::BITS_BASE + {1'b0, config_in.char_size};
        end
        if (config_in.double_speed)
        begin
            os_ratio = usart_rx_pkg::OS_DOUBLE;
            pos_a = usart_rx_pkg::DOUBLE_S0;
            pos_b = usart_rx_pkg::DOUBLE_S1;
            pos_c = usart_rx_pkg::DOUBLE_S2;
        end
        else
        begin
            os_ratio = usart_rx_pkg::OS_NORMAL;
            pos_a = usart_rx_pkg::NORMAL_S0;
            pos_b = usart_rx_pkg::NORMAL_S1;
            pos_c = usart_rx_pkg::NORMAL_S2;
        end
    end

    // Oversample tick: one every baud_div + 1 clocks
    always_ff @(posedge clock_in)
    begin
        if (reset_in || !rx_enable_bit_in || baud_cnt_reg == usart_rx_pkg::BAUD_RESET)
        begin
            baud_cnt_reg <= config_in.baud_div;
        end
        else
        begin
            baud_cnt_reg <= baud_cnt_reg - 8'h01;
        end
    end

    assign os_tick = rx_enable_bit_in && is_async && (baud_cnt_reg == usart_rx_pkg::BAUD_RESET);

    // Line and serial clock history
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            line_prev_reg <= 1'b1; // Idle line is high
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            if (os_tick)
            begin
                line_prev_reg <= rx_data_pin_in;
            end
            sclk_prev_reg <= serial_clock_pin_in;
        end
    end

    // Sampling edge: falling with polarity low, rising with polarity high
    assign sample_edge = config_in.clock_polarity ? (serial_clock_pin_in & ~sclk_prev_reg)
                                                  : (~serial_clock_pin_in & sclk_prev_reg);

    // Bit decision; a glitch on one centre sample is outvoted
    always_comb
    begin
        sample_num = sample_cnt_reg + 5'h01;
        vote_high = ({1'b0, high_votes_reg} + {2'b00, rx_data_pin_in}) >= {1'b0, usart_rx_pkg::VOTE_MAJORITY};
        if (is_async)
        begin
            bit_strobe = os_tick && (sample_num == pos_c);
            bit_end = os_tick && (sample_num == os_ratio);
            bit_value = vote_high;
        end
        else
        begin
            bit_strobe = sample_edge;
            bit_end = sample_edge;
            bit_value = rx_data_pin_in;
        end
        // MSB-first SPI fills from the top
        if (is_spi && !config_in.lsb_first)
        begin
            bit_pos = usart_rx_pkg::SPI_TOP_INDEX - bit_idx_reg;
        end
        else
        begin
            bit_pos = bit_idx_reg;
        end
        // The last SPI bit lands at bit_pos, which is the top bit when LSB first
        spi_word = shift_reg;
        spi_word[bit_pos] = bit_value;
        // Even parity is the XOR of the data bits, odd inverts it
        parity_bad = ((^shift_reg) ^ config_in.parity_odd) != parity_bit_reg;
    end

    // Sample counter and vote accumulator, restarted by each start
    always_ff @(posedge clock_in)
    begin
        if (reset_in || !rx_enable_bit_in || state_reg == usart_rx_pkg::ST_IDLE)
        begin
            // A detected start edge counts as sample one
            sample_cnt_reg <= 5'h01;
            high_votes_reg <= 2'h0;
        end
        else if (os_tick)
        begin
            if (sample_num == os_ratio)
            begin
                sample_cnt_reg <= 5'h00;
                high_votes_reg <= 2'h0;
            end
            else
            begin
                sample_cnt_reg <= sample_num;
                if ((sample_num == pos_a || sample_num == pos_b) && rx_data_pin_in)
                begin
                    high_votes_reg <= high_votes_reg + 2'h1;
                end
            end
        end
    end

    // Receive state machine
    always_ff @(posedge clock_in)
    begin
        frame_done_reg <= 1'b0;
        if (reset_in || !rx_enable_bit_in)
        begin
            // Disable abandons a frame in progress at once
            state_reg <= usart_rx_pkg::ST_IDLE;
            bit_idx_reg <= 4'h0;
            shift_reg <= usart_rx_pkg::DATA_RESET;
            parity_bit_reg <= 1'b0;
            frame_entry_reg <= '0;
        end
        else if (is_spi && !spi_selected)
        begin
            // Slave deselected: drop any partial byte
            state_reg <= usart_rx_pkg::ST_IDLE;
            bit_idx_reg <= 4'h0;
        end
        else
        begin
            case (state_reg)
                usart_rx_pkg::ST_IDLE:
                begin
                    bit_idx_reg <= 4'h0;
                    if (is_async && os_tick && line_prev_reg && !rx_data_pin_in)
                    begin
                        shift_reg <= usart_rx_pkg::DATA_RESET;
                        state_reg <= usart_rx_pkg::ST_START;
                    end
                    else if (is_spi && sample_edge)
                    begin
                        // SPI has no start bit: first edge carries data
                        shift_reg <= {8'h00, 1'b0};
                        shift_reg[bit_pos] <= rx_data_pin_in;
                        bit_idx_reg <= 4'h1;
                        state_reg <= usart_rx_pkg::ST_DATA;
                    end
                    else if (!is_async && !is_spi && sample_edge && !rx_data_pin_in)
                    begin
                        shift_reg <= usart_rx_pkg::DATA_RESET;
                        state_reg <= usart_rx_pkg::ST_DATA;
                    end
                end
                usart_rx_pkg::ST_START:
                begin
                    if (bit_strobe && bit_value)
                    begin
                        // Majority high: noise, not a start bit
                        state_reg <= usart_rx_pkg::ST_IDLE;
                    end
                    else if (bit_end)
                    begin
                        state_reg <= usart_rx_pkg::ST_DATA;
                    end
                end
                usart_rx_pkg::ST_DATA:
                begin
                    if (bit_strobe)
                    begin
                        shift_reg[bit_pos] <= bit_value;
                    end
                    if (bit_end)
                    begin
                        bit_idx_reg <= bit_idx_reg + 4'h1;
                        if (bit_idx_reg + 4'h1 == frame_bits)
                        begin
                            if (is_spi)
                            begin
                                state_reg <= usart_rx_pkg::ST_IDLE;
                                frame_done_reg <= 1'b1;
                                frame_entry_reg <= '{data: {1'b0, spi_word[7:0]},
                                                     frame_error: 1'b0, overrun: 1'b0, parity_error: 1'b0};
                            end
                            else if (config_in.parity_enable)
                            begin
                                state_reg <= usart_rx_pkg::ST_PARITY;
                            end
                            else
                            begin
                                state_reg <= usart_rx_pkg::ST_STOP;
                            end
                        end
                    end
                end
                usart_rx_pkg::ST_PARITY:
                begin
                    if (bit_strobe)
                    begin
                        parity_bit_reg <= bit_value;
                    end
                    if (bit_end)
                    begin
                        state_reg <= usart_rx_pkg::ST_STOP;
                    end
                end
                usart_rx_pkg::ST_STOP:
                begin
                    if (bit_strobe)
                    begin
                        // Decided mid-bit so a following start is not missed
                        state_reg <= usart_rx_pkg::ST_IDLE;
                        frame_done_reg <= 1'b1;
                        frame_entry_reg.data <= shift_reg;
                        frame_entry_reg.frame_error <= ~bit_value;
                        frame_entry_reg.overrun <= 1'b0;
                        frame_entry_reg.parity_error <= config_in.parity_enable & parity_bad;
                    end
                end
                default:
                begin
                    state_reg <= usart_rx_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Buffer control terms
    assign pop = data_read_in && (count_reg != usart_rx_pkg::BUF_EMPTY);
    assign push = frame_done_reg && (!lost_reg || pop) && (count_reg != usart_rx_pkg::BUF_FULL || pop);
    assign overrun_now = frame_done_reg && !push;
    // Free slot is head plus occupancy; a read in the same cycle does not move it
    assign tail = head_reg ^ count_reg[0];

    // Buffer occupancy, head and overrun hold
    always_ff @(posedge clock_in)
    begin
        if (reset_in || !rx_enable_bit_in)
        begin
            count_reg <= usart_rx_pkg::BUF_EMPTY;
            head_reg <= 1'b0;
            lost_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
            if (pop)
            begin
                head_reg <= ~head_reg;
            end
            // A frame in the same cycle as a read is stored, not lost
            if (overrun_now)
            begin
                lost_reg <= 1'b1;
            end
            else if (pop)
            begin
                lost_reg <= 1'b0;
            end
        end
    end

    // Buffer entries: data and flags written together on a push; the overrun mark is set on its own later
    for (genvar i = 0; i < 2; i++)
    begin : g_entry
        always_ff @(posedge clock_in)
        begin
            if (reset_in || !rx_enable_bit_in)
            begin
                entry_reg[i] <= '0;
            end
            else if (push && tail == 1'(i))
            begin
                entry_reg[i] <= frame_entry_reg;
            end
            else if (overrun_now && head_reg != 1'(i))
            begin
                // Newest entry carries the overrun mark
                entry_reg[i].overrun <= 1'b1;
            end
        end
    end

    assign head_entry = head_reg ? entry_reg[1] : entry_reg[0];

    // Registered status and pins
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            data_out_reg <= 8'h00;
            ninth_out_reg <= 1'b0;
            fe_out_reg <= 1'b0;
            dor_out_reg <= 1'b0;
            pe_out_reg <= 1'b0;
            rxc_out_reg <= 1'b0;
            irq_out_reg <= 1'b0;
            claim_reg <= 1'b0;
            ss_out_reg <= 1'b1;
            ss_oe_reg <= 1'b0;
        end
        else
        begin
            data_out_reg <= head_entry.data[7:0];
            ninth_out_reg <= head_entry.data[8];
            fe_out_reg <= head_entry.frame_error;
            dor_out_reg <= head_entry.overrun;
            pe_out_reg <= head_entry.parity_error & config_in.parity_enable;
            rxc_out_reg <= (count_reg != usart_rx_pkg::BUF_EMPTY);
            irq_out_reg <= (count_reg != usart_rx_pkg::BUF_EMPTY) && config_in.rx_complete_irq_enable
                           && config_in.global_irq_enable;
            claim_reg <= rx_enable_bit_in;
            ss_oe_reg <= is_spi && config_in.master && config_in.slave_select_out_enable;
            ss_out_reg <= (state_reg == usart_rx_pkg::ST_IDLE);
        end
    end

    assign data_buffer_reg_out = data_out_reg;
    assign rx_ninth_bit_out = ninth_out_reg;
    assign frame_error_flag_out = fe_out_reg;
    assign overrun_flag_out = dor_out_reg;
    assign parity_error_flag_out = pe_out_reg;
    assign rx_complete_flag_out = rxc_out_reg;
    assign rx_irq_out = irq_out_reg;
    assign rx_pin_claim_out = claim_reg;
    assign slave_select_pin_out = ss_out_reg;
    assign slave_select_pin_oe_out = ss_oe_reg;

    // Checks
    sequence s_start_noise;
        state_reg == usart_rx_pkg::ST_START && bit_strobe && bit_value;
    endsequence

    sequence s_stop_taken;
        state_reg == usart_rx_pkg::ST_STOP && bit_strobe;
    endsequence

    a_start_reject: assert property (@(posedge clock_in) disable iff (reset_in || !rx_enable_bit_in)
        s_start_noise |=> state_reg == usart_rx_pkg::ST_IDLE && !frame_done_reg)
        else $error("noisy start bit not rejected");
    a_stop_finish: assert property (@(posedge clock_in) disable iff (reset_in || !rx_enable_bit_in)
        s_stop_taken |=> frame_done_reg && state_reg == usart_rx_pkg::ST_IDLE
            && frame_entry_reg.frame_error == !$past(bit_value))
        else $error("stop bit did not complete frame");
    a_disable_flush: assert property (@(posedge clock_in) disable iff (reset_in)
        !rx_enable_bit_in |=> count_reg == usart_rx_pkg::BUF_EMPTY && state_reg == usart_rx_pkg::ST_IDLE
            ##1 !rx_complete_flag_out)
        else $error("disable did not flush receiver");
    a_flag_tracks: assert property (@(posedge clock_in) disable iff (reset_in)
        ##1 rx_complete_flag_out == ($past(count_reg) != usart_rx_pkg::BUF_EMPTY))
        else $error("receive complete flag wrong");
    a_irq_gate: assert property (@(posedge clock_in) disable iff (reset_in)
        rx_irq_out == (rx_complete_flag_out && $past(config_in.rx_complete_irq_enable)
            && $past(config_in.global_irq_enable)))
        else $error("interrupt does not follow its causes");
    a_parity_off: assert property (@(posedge clock_in) disable iff (reset_in)
        !$past(config_in.parity_enable) |-> !parity_error_flag_out)
        else $error("parity error shown while disabled");
    a_depth_bound: assert property (@(posedge clock_in) disable iff (reset_in)
        count_reg <= usart_rx_pkg::BUF_FULL)
        else $error("buffer holds more than two entries");
    // The mark goes on the newest stored entry and shows only when it reaches the head
    a_overrun_drop: assert property (@(posedge clock_in) disable iff (reset_in || !rx_enable_bit_in)
        frame_done_reg && count_reg == usart_rx_pkg::BUF_FULL && !data_read_in
            |=> count_reg == usart_rx_pkg::BUF_FULL && lost_reg
            && (head_reg ? entry_reg[0].overrun : entry_reg[1].overrun))
        else $error("overrun not marked or data stored");
    a_pop_advance: assert property (@(posedge clock_in) disable iff (reset_in || !rx_enable_bit_in)
        pop && !push |=> count_reg == $past(count_reg) - 2'h1 && head_reg != $past(head_reg))
        else $error("read did not pop oldest entry");

endmodule : usart_receiver_spi_select

/* tb/uart_tx_model.sv */
`timescale 1ns/1ns
// Far-end transmitter driving the receive line
module uart_tx_model (
    input wire logic clock_in,
    output logic line_out,
    output logic sclk_out
);
    // Idle line sits high between frames
    initial line_out = 1'b1;
    // Serial clock idles low outside transfers
    initial sclk_out = 1'b0;
    // Start bit in bit 0, data LSB first, then parity and stop
    task automatic send(input logic [10:0] bits, input int n, input int clocks);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clock_in);
            line_out = bits[i];
            repeat (clocks - 1) @(negedge clock_in);
        end
        @(negedge clock_in);
        line_out = 1'b1;
    endtask : send
    // One bit per serial clock: data set with the rise, taken at the fall
    task automatic clocked_send(input logic [10:0] bits, input int n, input int clocks);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clock_in);
            line_out = bits[i];
            sclk_out = 1'b1;
            repeat (clocks) @(negedge clock_in);
            sclk_out = 1'b0;
            repeat (clocks - 1) @(negedge clock_in);
        end
        @(negedge clock_in);
        line_out = 1'b1;
    endtask : clocked_send
endmodule : uart_tx_model

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic rx_enable_bit_in = 1'b0;
    logic data_read_in = 1'b0;
    logic rx_line;
    usart_rx_pkg::rx_config_type cfg = '0;
    logic [7:0] data;
    logic ninth, fe, ov, pe, done, irq, claim;
    logic sclk;
    logic ss_n = 1'b1;
    logic ss_pin, ss_oe;
    int fails = 0;
    int n_compared = 0;
    int bit_clocks = 16; // Oversample tick every clock, so 16 clocks a bit
    // Free-running 250 MHz clock
    always #2 clock_in = ~clock_in;
    uart_tx_model i_uart_tx_model (.clock_in(clock_in), .line_out(rx_line), .sclk_out(sclk));
    usart_receiver_spi_select i_usart_receiver_spi_select (.clock_in(clock_in), .reset_in(reset_in),
        .rx_enable_bit_in(rx_enable_bit_in), .config_in(cfg), .rx_data_pin_in(rx_line),
        .serial_clock_pin_in(sclk), .slave_select_pin_n_in(ss_n), .data_read_in(data_read_in),
        .data_buffer_reg_out(data), .rx_ninth_bit_out(ninth), .frame_error_flag_out(fe),
        .overrun_flag_out(ov), .parity_error_flag_out(pe), .rx_complete_flag_out(done), .rx_irq_out(irq),
        .rx_pin_claim_out(claim), .slave_select_pin_out(ss_pin), .slave_select_pin_oe_out(ss_oe));
    // One comparison of a result against its expectation
    task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Send a frame; status lands three clocks after the stop decision
    task automatic send(input logic [10:0] bits, input int n);
        i_uart_tx_model.send(bits, n, bit_clocks);
        repeat (4) @(negedge clock_in);
    endtask : send
    // Clocked transfer, four clocks per serial clock phase
    task automatic clocked(input logic [10:0] bits, input int n);
        i_uart_tx_model.clocked_send(bits, n, 4);
        repeat (4) @(negedge clock_in);
    endtask : clocked
    // One-cycle read, outputs settle two clocks later
    task automatic pop;
        data_read_in = 1'b1;
        @(negedge clock_in);
        data_read_in = 1'b0;
        repeat (2) @(negedge clock_in);
    endtask : pop
    // Even and odd parity, good and bad parity bit
    task automatic t_parity;
        logic [7:0] d;
        cfg.parity_enable = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            d = 8'hA5 + 8'(k);
            cfg.parity_odd = k[0];
            send({1'b1, ^d ^ k[0] ^ k[1], d, 1'b0}, 11);
            check("data", {1'b0, d}, {ninth, data});
            check("parity_error", 9'(k[1]), 9'(pe));
            check("complete_irq", 9'h003, {7'h00, done, irq});
            pop();
            check("empty", 9'h000, {7'h00, done, irq});
        end
        cfg.parity_enable = 1'b0;
        send({2'h3, 8'h0F ^ 8'h01, 1'b0}, 11);
        check("parity_off", 9'h000, 9'(pe));
        pop();
        $display("test parity done");
    endtask : t_parity
    // Stop bit sampled low, and a start glitch too short to qualify
    task automatic t_frame;
        send({2'h2, 8'h3C, 1'b0}, 10);
        check("frame_error", 9'h001, 9'(fe));
        pop();
        i_uart_tx_model.send(11'h000, 1, 4);
        repeat (200) @(negedge clock_in);
        check("glitch", 9'h000, 9'(done));
        $display("test frame done");
    endtask : t_frame
    // Three frames into a two-entry buffer
    task automatic t_overrun;
        send({2'h3, 8'h11, 1'b0}, 10);
        send({2'h3, 8'h22, 1'b0}, 10);
        send({2'h3, 8'h33, 1'b0}, 10);
        check("head", 9'h011, {ov, data});
        pop();
        check("second", 9'h122, {ov, data});
        pop();
        check("drained", 9'h000, 9'(done));
        send({2'h3, 8'h44, 1'b0}, 10);
        check("after", 9'h044, {ov, data});
        pop();
        $display("test overrun done");
    endtask : t_overrun
    // SPI master both bit orders, slave deselected and selected, then synchronous
    task automatic t_clocked;
        cfg.mode = usart_rx_pkg::MODE_SPI;
        cfg.master = 1'b1;
        cfg.slave_select_out_enable = 1'b1;
        cfg.lsb_first = 1'b1;
        clocked(11'h035, 8);
        check("spi_lsb", 9'h035, {ninth, data});
        check("ss_pin", 9'h003, {7'h00, ss_oe, ss_pin});
        pop();
        cfg.lsb_first = 1'b0;
        cfg.global_irq_enable = 1'b0;
        clocked(11'h035, 8);
        check("spi_msb", 9'h0AC, {ninth, data});
        check("irq_gated", 9'h002, {7'h00, done, irq});
        pop();
        cfg.global_irq_enable = 1'b1;
        cfg.master = 1'b0;
        clocked(11'h035, 8);
        check("deselected", 9'h000, 9'(done));
        ss_n = 1'b0;
        clocked(11'h035, 8);
        check("selected", 9'h0AC, {ninth, data});
        pop();
        ss_n = 1'b1;
        cfg.mode = usart_rx_pkg::MODE_SYNC;
        clocked({2'h3, 8'h96, 1'b0}, 10);
        check("sync", 9'h096, {fe, data});
        pop();
        cfg.mode = usart_rx_pkg::MODE_ASYNC;
        $display("test clocked done");
    endtask : t_clocked
    // Nine-bit characters, double speed, then disable mid-buffer
    task automatic t_modes;
        cfg.char_size = usart_rx_pkg::SIZE_NINE;
        send({1'b1, 9'h1A5, 1'b0}, 11);
        check("ninth", 9'h1A5, {ninth, data});
        pop();
        cfg.char_size = usart_rx_pkg::SIZE_EIGHT;
        cfg.double_speed = 1'b1;
        bit_clocks = 8;
        send({2'h3, 8'h5A, 1'b0}, 10);
        check("double", 9'h05A, {1'b0, data});
        rx_enable_bit_in = 1'b0;
        repeat (3) @(negedge clock_in);
        check("flush", 9'h000, {7'h00, done, claim});
        send({2'h3, 8'h77, 1'b0}, 10);
        check("off", 9'h000, 9'(done));
        $display("test modes done");
    endtask : t_modes
    // Verdict and end of run
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clock_in);
        fails++;
        report_and_stop();
    end
    // Main sequence
    initial
    begin
        cfg.char_size = usart_rx_pkg::SIZE_EIGHT;
        cfg.rx_complete_irq_enable = 1'b1;
        cfg.global_irq_enable = 1'b1;
        repeat (4) @(negedge clock_in);
        reset_in = 1'b0;
        rx_enable_bit_in = 1'b1;
        @(negedge clock_in);
        t_parity();
        t_frame();
        t_overrun();
        t_clocked();
        t_modes();
        report_and_stop();
    end
endmodule : testbench
